/* see_device.sv */
// Serial memory device end: two-wire slave with page write and reads
// How it works
// R1: byte write: address, word, data, each acknowledged
// R2: programming starts at STOP after data
// R3: busy device releases line, answers nothing
// R4: up to 16 bytes per programming cycle
// R5: master may send fifteen more bytes
// R6: write increments low four address bits
// R7: over sixteen bytes wraps within page
// R8: STOP commits buffered page at once
// R9: poll: no acknowledge while busy, else acknowledge
// R10: protect high refuses writes; low harmless
// R11: protect sampled at edge before data
// R12: protected: data not acknowledged, write discarded
// R13: memory starts erased to FFh
// R14: read address acknowledged, current byte sent
// R15: no acknowledge then STOP ends read
// R16: random read via dummy write, restart
// R17: master acknowledge continues sequential read
// R18: read counter wraps at memory end
// R19: address byte 1010, pins, ninth bit, direction
// R20: acknowledge low on ninth clock; release sending
// R21: counter kept between commands
`timescale 1ns/1ps
`include "see_params.svh"
module see_device #(
  parameter int PROG_CYCLES = `SEE_PROG_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Straps
  input wire logic select_pin_low_i,
  input wire logic select_pin_high_i,
  input wire logic write_protect_i,
  // Link
  see_link_if.device link,
  // Status
  output logic busy_o
);
  import see_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_WORD = 6'h04,
    ST_DATA = 6'h08,
    ST_SEND = 6'h10,
    ST_IGNORE = 6'h20
  } see_dev_state_type;

  // R13: array starts erased; reset leaves contents alone
  logic [7:0] mem_q [0:`SEE_MEM_BYTES-1] = '{default: `SEE_ERASED};
  logic [7:0] page_q [0:`SEE_PAGE_BYTES-1];
  logic [`SEE_PAGE_BYTES-1:0] page_vld_q;

  see_dev_state_type state_q;
  logic scl_q, sda_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [8:0] addr_q;
  logic [8:0] wbase_q;
  logic rd_q, wp_q, nack_q, first_q, pend_q;
  logic [31:0] prog_q;
  logic oe_q;
  logic busy_q;

  // Bus event decode; SDA only moves while SCL low in normal data
  wire scl_rise = link.scl & ~scl_q;
  wire scl_fall = ~link.scl & scl_q;
  wire start_ev = link.scl & scl_q & sda_q & ~link.sda;
  wire stop_ev = link.scl & scl_q & ~sda_q & link.sda;
  wire [7:0] sh_next = {sh_q[6:0], link.sda};
  // R19: type and select pins only; ninth bit is loaded separately
  wire addr_hit = sh_next[7:4] == `SEE_DEV_TYPE &&
    sh_next[3] == select_pin_high_i && sh_next[2] == select_pin_low_i;
  wire [8:0] addr_inc = addr_q + 9'h001;
  wire [8:0] page_inc = {addr_q[8:4], addr_q[3:0] + 4'h1};
  wire byte_done = scl_rise && bit_q == 4'h7;
  wire ack_slot = bit_q == 4'h8;

  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe = oe_q;
  assign busy_o = busy_q;

  // Programming commit; write all buffered bytes of the page at once
  always_ff @(posedge clk_sys_i) begin
    if (pend_q) begin
      // R8: commit every buffered byte together
      for (int j = 0; j < `SEE_PAGE_BYTES; j++) begin
        if (page_vld_q[j]) begin
          mem_q[{wbase_q[8:4], 4'(j)}] <= page_q[j];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    scl_q <= link.scl;
    sda_q <= link.sda;
    if (srst_i) begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      addr_q <= 9'h000;
      wbase_q <= 9'h000;
      rd_q <= 1'b0;
      wp_q <= 1'b0;
      nack_q <= 1'b0;
      first_q <= 1'b0;
      pend_q <= 1'b0;
      prog_q <= 32'h0;
      oe_q <= 1'b0;
      busy_q <= 1'b0;
      page_vld_q <= '0;
    end else begin
      pend_q <= 1'b0;
      if (prog_q != 32'h0) begin
        prog_q <= prog_q - 32'h1;
        busy_q <= prog_q != 32'h1;
      end
      if (start_ev) begin
        state_q <= ST_ADDR;
        bit_q <= 4'h0;
        oe_q <= 1'b0;
      end else if (stop_ev) begin
        // R2: a STOP after data starts programming
        if (state_q == ST_DATA && page_vld_q != '0 && !busy_q) begin
          pend_q <= 1'b1;
          prog_q <= 32'(PROG_CYCLES);
          busy_q <= 1'b1;
        end
        // R15: any STOP returns to standby
        state_q <= ST_IDLE;
        oe_q <= 1'b0;
      end else if (state_q == ST_SEND) begin
        // R17: acknowledge slot sampled; own ack reads as low
        if (scl_rise && bit_q == 4'h8) begin
          nack_q <= link.sda;
        end
        if (scl_fall && bit_q == 4'h8) begin
          if (nack_q) begin
            // R15: no acknowledge, stay off the line until STOP
            oe_q <= 1'b0;
            state_q <= ST_IGNORE;
          end else begin
            // R14: shift out byte at current counter
            oe_q <= ~mem_q[addr_q][7];
            sh_q <= {mem_q[addr_q][6:0], 1'b0};
            bit_q <= 4'h0;
            // R18 R21: full counter wraps, keeps one past
            addr_q <= addr_inc;
          end
        end else if (scl_fall && bit_q == 4'h7) begin
          // R20: release line for master acknowledge slot
          oe_q <= 1'b0;
          bit_q <= 4'h8;
        end else if (scl_fall) begin
          oe_q <= ~sh_q[7];
          sh_q <= {sh_q[6:0], 1'b0};
          bit_q <= bit_q + 4'h1;
        end
      end else if (state_q != ST_IDLE && state_q != ST_IGNORE) begin
        if (scl_rise && !ack_slot) begin
          sh_q <= sh_next;
          bit_q <= bit_q + 4'h1;
        end else if (scl_rise && ack_slot) begin
          // Ninth clock high; release follows on its falling edge
          bit_q <= 4'h9;
        end
        if (byte_done) begin
          case (state_q)
            ST_ADDR: begin
              // R3: busy device ignores everything; R9: no acknowledge
              if (!addr_hit || busy_q) begin
                state_q <= ST_IGNORE;
              end else begin
                rd_q <= sh_next[0];
                addr_q[8] <= sh_next[1];
              end
            end
            ST_WORD: begin
              // R1 R16: word address loads the counter
              addr_q[7:0] <= sh_next;
              wbase_q <= {addr_q[8], sh_next};
              page_vld_q <= '0;
              first_q <= 1'b1;
            end
            ST_DATA: begin
              // R12: protected write is discarded
              if (wp_q) begin
                state_q <= ST_IGNORE;
              end else begin
                // R4 R7: one page buffer, later bytes replace earlier
                page_q[addr_q[3:0]] <= sh_next;
                page_vld_q[addr_q[3:0]] <= 1'b1;
                // R6: only the low four bits advance
                addr_q <= page_inc;
              end
            end
            default: begin
            end
          endcase
        end
        if (scl_fall) begin
          // R11: protect sampled before first data bit
          if (state_q == ST_DATA && first_q && bit_q == 4'h9) begin
            wp_q <= write_protect_i;
            first_q <= 1'b0;
          end
          if (bit_q == 4'h8 && !oe_q) begin
            // R20: acknowledge on ninth clock; R12 withholds it
            oe_q <= !(state_q == ST_DATA && wp_q);
            if (state_q == ST_ADDR && rd_q) begin
              state_q <= ST_SEND;
            end else if (state_q == ST_ADDR) begin
              state_q <= ST_WORD;
            end else begin
              state_q <= ST_DATA;
            end
            // R10: protect level steers data acknowledge
            if (state_q == ST_DATA && wp_q) begin
              state_q <= ST_IGNORE;
            end
          end else if (bit_q == 4'h9 && oe_q) begin
            oe_q <= 1'b0;
            bit_q <= 4'h0;
          end
        end
      end
    end
  end
endmodule

/* see_link_if.sv */
// Two-wire link between the memory device and its bus master
`timescale 1ns/1ps
interface see_link_if;
  logic scl;
  logic sda_out;
  logic sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  wire sda;
  // Open-drain wire: low if either end drives, else pulled high
  assign sda = ~((sda_oe & ~sda_out) | (dev_sda_oe & ~dev_sda_out));
  modport master (output scl, output sda_out, output sda_oe, input sda);
  modport device (input scl, output dev_sda_out, output dev_sda_oe, input sda);
endinterface

/* see_link_properties.sv */
// Concurrent checks on the two-wire link between both ends
`timescale 1ns/1ps
module see_link_properties #(
  parameter int PROG_CYCLES = 200
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Link and device status
  input wire logic scl,
  input wire logic sda_oe,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire sda,
  input wire logic busy_o
);
  logic [31:0] busy_cnt_q;
  logic [31:0] busy_cnt_d;

  // Length of the running programming cycle, cleared when idle
  assign busy_cnt_d = busy_o ? busy_cnt_q + 32'h1 : 32'h0;
  always_ff @(posedge clk_sys_i) begin
    busy_cnt_q <= srst_i ? 32'h0 : busy_cnt_d;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  chk_dev_open_drain: assert property (dev_sda_out == 1'b0)
    else $error("device drives sda high");
  chk_dev_sda_stable: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device moved sda while scl high");
  chk_frame_by_master: assert property ($changed(sda) && scl && $past(scl) |-> $changed(sda_oe))
    else $error("start or stop not made by master");
  chk_busy_released: assert property (busy_o |-> !dev_sda_oe)
    else $error("device drove sda while programming");
  chk_busy_at_stop: assert property ($rose(busy_o) |-> scl && sda && !sda_oe)
    else $error("programming began outside a stop");
  chk_busy_length: assert property ($fell(busy_o) |->
      busy_cnt_q >= PROG_CYCLES - 1 && busy_cnt_q <= PROG_CYCLES + 1)
    else $error("programming time wrong");
  chk_scl_high_min: assert property ($rose(scl) |=> scl [*8])
    else $error("scl high phase too short");
  chk_scl_low_min: assert property ($fell(scl) |=> !scl [*8])
    else $error("scl low phase too short");
  chk_reset_idle: assert property (disable iff (1'b0)
      $fell(srst_i) |-> scl && !sda_oe && !dev_sda_oe)
    else $error("link not idle after reset");
endmodule

/* see_master.sv */
// Bus master end: runs write, poll and read commands on the two-wire link
`timescale 1ns/1ps
`include "see_params.svh"
module see_master (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Command
  input wire logic cmd_valid_i,
  input wire see_pkg::see_cmd_type cmd_i,
  input wire logic [1:0] select_i,
  input wire logic [8:0] addr_i,
  input wire logic [4:0] count_i,
  input wire logic [7:0] wdata_i,
  // Answer
  output logic cmd_ready_o,
  output logic wdata_take_o,
  output logic rdata_valid_o,
  output logic [7:0] rdata_o,
  output logic nack_o,
  output logic done_o,
  // Link
  see_link_if.master link
);
  import see_pkg::*;

  typedef enum logic [4:0] {
    MS_IDLE = 5'h01,
    MS_START = 5'h02,
    MS_BIT = 5'h04,
    MS_STOP = 5'h08,
    MS_DONE = 5'h10
  } see_mst_state_type;

  see_mst_state_type state_q;
  see_cmd_type cmd_q;
  logic [7:0] half_q;
  logic [3:0] bit_q;
  logic [1:0] ph_q;
  logic [7:0] tx_q, rx_q;
  logic [2:0] byte_q;
  logic [4:0] left_q;
  logic restart_q, scl_q, oe_q, rdy_q, take_q, rv_q, nack_q, done_q;
  logic [1:0] sel_q;
  logic [8:0] addr_q;

  wire tick = half_q == 8'h00;
  wire reading = (cmd_q == SEE_CMD_READ_CUR) || (cmd_q == SEE_CMD_READ_RND && restart_q);
  wire [7:0] addr_byte = {`SEE_DEV_TYPE, sel_q, addr_q[8], reading};

  assign link.scl = scl_q;
  assign link.sda_out = 1'b0;
  assign link.sda_oe = oe_q;
  assign cmd_ready_o = rdy_q;
  assign wdata_take_o = take_q;
  assign rdata_valid_o = rv_q;
  assign rdata_o = rx_q;
  assign nack_o = nack_q;
  assign done_o = done_q;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state_q <= MS_IDLE;
      cmd_q <= SEE_CMD_WRITE;
      half_q <= 8'h00;
      bit_q <= 4'h0;
      ph_q <= 2'h0;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      byte_q <= 3'h0;
      left_q <= 5'h00;
      restart_q <= 1'b0;
      scl_q <= 1'b1;
      oe_q <= 1'b0;
      rdy_q <= 1'b1;
      take_q <= 1'b0;
      rv_q <= 1'b0;
      nack_q <= 1'b0;
      done_q <= 1'b0;
      sel_q <= 2'h0;
      addr_q <= 9'h000;
    end else begin
      take_q <= 1'b0;
      rv_q <= 1'b0;
      done_q <= 1'b0;
      half_q <= tick ? `SEE_HALF_CYCLES : half_q - 8'h01;
      case (state_q)
        MS_IDLE: begin
          if (cmd_valid_i) begin
            cmd_q <= cmd_i;
            sel_q <= select_i;
            addr_q <= addr_i;
            left_q <= count_i;
            restart_q <= 1'b0;
            nack_q <= 1'b0;
            rdy_q <= 1'b0;
            ph_q <= 2'h0;
            state_q <= MS_START;
          end
        end
        MS_START: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: begin scl_q <= 1'b0; oe_q <= 1'b0; end
              2'h1: scl_q <= 1'b1;
              2'h2: oe_q <= 1'b1;
              default: begin
                scl_q <= 1'b0;
                tx_q <= addr_byte;
                oe_q <= ~addr_byte[7];
                bit_q <= 4'h0;
                byte_q <= 3'h0;
                ph_q <= 2'h0;
                state_q <= MS_BIT;
              end
            endcase
          end
        end
        MS_BIT: begin
          if (tick && !scl_q) begin
            scl_q <= 1'b1;
            if (bit_q == 4'h8 && !(reading && byte_q != 3'h0)) begin
              // Device acknowledge sampled on ninth clock
              if (link.sda) begin
                nack_q <= 1'b1;
              end
            end else if (reading && byte_q != 3'h0 && bit_q < 4'h8) begin
              rx_q <= {rx_q[6:0], link.sda};
            end
          end else if (tick && scl_q) begin
            scl_q <= 1'b0;
            bit_q <= bit_q + 4'h1;
            if (bit_q < 4'h7) begin
              oe_q <= (reading && byte_q != 3'h0) ? 1'b0 : ~tx_q[6 - bit_q[2:0]];
            end else if (bit_q == 4'h7) begin
              // Ninth clock: release, or acknowledge read data
              oe_q <= reading && byte_q != 3'h0 && left_q > 5'h01;
              if (reading && byte_q != 3'h0) begin
                rv_q <= 1'b1;
              end
            end else begin
              bit_q <= 4'h0;
              // Saturate so long transfers never look like an address byte
              byte_q <= (byte_q == 3'h7) ? byte_q : byte_q + 3'h1;
              oe_q <= 1'b0;
              if (nack_q || cmd_q == SEE_CMD_POLL) begin
                state_q <= MS_STOP;
              end else if (cmd_q == SEE_CMD_READ_RND && !restart_q && byte_q == 3'h1) begin
                restart_q <= 1'b1;
                scl_q <= 1'b0;
                state_q <= MS_START;
              end else if (reading) begin
                if (byte_q != 3'h0) begin
                  left_q <= left_q - 5'h01;
                end
                if (byte_q != 3'h0 && left_q <= 5'h01) begin
                  state_q <= MS_STOP;
                end
              end else if (byte_q == 3'h0) begin
                tx_q <= addr_q[7:0];
                oe_q <= ~addr_q[7];
              end else if (left_q == 5'h00) begin
                state_q <= MS_STOP;
              end else begin
                tx_q <= wdata_i;
                oe_q <= ~wdata_i[7];
                take_q <= 1'b1;
                left_q <= left_q - 5'h01;
              end
            end
          end
        end
        MS_STOP: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: oe_q <= 1'b1;
              2'h1: scl_q <= 1'b1;
              default: begin
                oe_q <= 1'b0;
                state_q <= MS_DONE;
              end
            endcase
          end
        end
        default: begin
          done_q <= 1'b1;
          rdy_q <= 1'b1;
          state_q <= MS_IDLE;
        end
      endcase
    end
  end
endmodule

/* see_params.svh */
// Constants shared by the serial memory device end and the bus master end
`ifndef SEE_PARAMS_SVH
`define SEE_PARAMS_SVH
`define SEE_DEV_TYPE 4'hA
`define SEE_MEM_BYTES 512
`define SEE_PAGE_BYTES 16
`define SEE_ERASED 8'hFF
`define SEE_CLK_MHZ 50
`define SEE_PROG_TIME_US 4000
`define SEE_PROG_CYCLES (`SEE_PROG_TIME_US * `SEE_CLK_MHZ)
`define SEE_HALF_CYCLES 8'h32
`endif

/* see_pkg.sv */
// Types shared by both ends of the serial memory link
package see_pkg;
  typedef enum logic [3:0] {
    SEE_CMD_WRITE = 4'h1,
    SEE_CMD_READ_CUR = 4'h2,
    SEE_CMD_READ_RND = 4'h4,
    SEE_CMD_POLL = 4'h8
  } see_cmd_type;
endpackage

/* tb.sv */
// Self-checking bench joining the memory device and its bus master
`timescale 1ns/1ps
module tb;
  import see_pkg::*;
  localparam int PROG = 1500;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic [1:0] straps = 2'h0;
  logic protect = 1'b0;
  logic cmd_valid = 1'b0;
  see_cmd_type cmd = SEE_CMD_READ_CUR;
  logic [1:0] sel = 2'h0;
  logic [8:0] addr = 9'h0;
  logic [4:0] count = 5'h1;
  logic [7:0] wdata = 8'h0;
  logic cmd_ready, wdata_take, rdata_valid, nack, done, busy;
  logic [7:0] rdata;
  logic [7:0] mem [512];
  logic [7:0] wb [32];
  logic [7:0] rd_q [$];
  logic [7:0] nk_q [$];
  logic [8:0] cur = 9'h0;
  int mismatches = 0;
  int num_checks = 0;

  see_link_if see_link_if_inst();
  see_device #(.PROG_CYCLES(PROG)) see_device_inst (.clk_sys_i(clk_sys_i),
    .srst_i(srst_i), .select_pin_low_i(straps[0]), .select_pin_high_i(straps[1]),
    .write_protect_i(protect), .link(see_link_if_inst), .busy_o(busy));
  see_master see_master_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .cmd_valid_i(cmd_valid), .cmd_i(cmd), .select_i(sel), .addr_i(addr),
    .count_i(count), .wdata_i(wdata), .cmd_ready_o(cmd_ready),
    .wdata_take_o(wdata_take), .rdata_valid_o(rdata_valid), .rdata_o(rdata),
    .nack_o(nack), .done_o(done), .link(see_link_if_inst));
  see_link_properties #(.PROG_CYCLES(PROG)) see_link_properties_inst (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .scl(see_link_if_inst.scl),
    .sda_oe(see_link_if_inst.sda_oe), .dev_sda_out(see_link_if_inst.dev_sda_out),
    .dev_sda_oe(see_link_if_inst.dev_sda_oe), .sda(see_link_if_inst.sda),
    .busy_o(busy));

  // Free-running system clock
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One command; notes its results first, then feeds bytes as taken
  task automatic run(input see_cmd_type c, input logic [8:0] a, input int n,
      input logic s_ok, input logic w, input logic late, input logic enack);
    int idx;
    int t;
    idx = 0;
    t = 0;
    nk_q.push_back({7'h0, enack});
    if (!enack && c != SEE_CMD_WRITE && c != SEE_CMD_POLL) begin
      cur = (c == SEE_CMD_READ_RND) ? a : cur;
      for (int i = 0; i < n; i++) begin
        rd_q.push_back(mem[cur]);
        cur = cur + 9'h1;
      end
    end
    // Only the low four address bits advance on writes
    for (int i = 0; i < n && !enack && c == SEE_CMD_WRITE; i++) begin
      mem[{a[8:4], 4'(a[3:0] + i)}] = wb[i];
    end
    @(negedge clk_sys_i);
    cmd = c;
    addr = a;
    count = 5'(n);
    protect = w;
    wdata = wb[0];
    sel = s_ok ? straps : ~straps;
    cmd_valid = 1'b1;
    @(posedge clk_sys_i);
    while (cmd_ready !== 1'b1) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && t < 40000) begin
      @(posedge clk_sys_i);
      t++;
      if (wdata_take === 1'b1) begin
        idx++;
        @(negedge clk_sys_i);
        wdata = wb[idx % 32];
        protect = (late && idx > 1) ? 1'b1 : protect;
      end
    end
    // A command that never finishes is a failure
    if (done !== 1'b1) begin
      mismatches++;
      complete_run();
    end
  endtask

  // Busy right after the write, poll refused, then poll answered
  task automatic after_write();
    int t;
    t = 0;
    @(negedge clk_sys_i);
    check({7'h0, busy}, 8'h01);
    run(SEE_CMD_POLL, 9'h0, 0, 1'b1, 1'b0, 1'b0, 1'b1);
    while (busy !== 1'b0 && t < 5000) begin
      @(negedge clk_sys_i);
      t++;
    end
    run(SEE_CMD_POLL, 9'h0, 0, 1'b1, 1'b0, 1'b0, 1'b0);
  endtask

  // Scoreboard: oldest note against each result as it appears
  always @(posedge clk_sys_i) begin
    if (rdata_valid === 1'b1) begin
      check(rdata, rd_q.size() > 0 ? rd_q.pop_front() : 8'hxx);
    end
    if (done === 1'b1) begin
      check({7'h0, nack}, nk_q.size() > 0 ? nk_q.pop_front() : 8'hxx);
    end
  end

  // Watchdog sized well above the whole sequence
  initial begin
    repeat (95000) @(posedge clk_sys_i);
    mismatches++;
    complete_run();
  end

  initial begin
    void'($urandom(23));
    straps = 2'($urandom());
    for (int i = 0; i < 32; i++) wb[i] = 8'($urandom());
    for (int i = 0; i < 512; i++) mem[i] = 8'hFF;
    repeat (5) @(negedge clk_sys_i);
    srst_i = 1'b0;
    run(SEE_CMD_READ_RND, 9'h0A3, 1, 1'b1, 1'b0, 1'b0, 1'b0);
    // eighteen bytes wrap inside the top page
    run(SEE_CMD_WRITE, 9'h1F5, 18, 1'b1, 1'b0, 1'b0, 1'b0);
    after_write();
    run(SEE_CMD_READ_RND, 9'h1F0, 16, 1'b1, 1'b0, 1'b0, 1'b0);
    // wrap at memory end, then continue from counter
    run(SEE_CMD_READ_RND, 9'h1FF, 3, 1'b1, 1'b0, 1'b0, 1'b0);
    run(SEE_CMD_READ_CUR, 9'h0, 2, 1'b1, 1'b0, 1'b0, 1'b0);
    run(SEE_CMD_WRITE, 9'h010, 1, 1'b1, 1'b1, 1'b0, 1'b1);
    @(negedge clk_sys_i);
    check({7'h0, busy}, 8'h00);
    run(SEE_CMD_READ_RND, 9'h010, 1, 1'b1, 1'b0, 1'b0, 1'b0);
    // protect raised after the strobe edge is ignored
    for (int i = 0; i < 32; i++) wb[i] = 8'($urandom());
    run(SEE_CMD_WRITE, 9'h020, 2, 1'b1, 1'b0, 1'b1, 1'b0);
    after_write();
    run(SEE_CMD_READ_RND, 9'h020, 2, 1'b1, 1'b0, 1'b0, 1'b0);
    // wrong select bits get no answer
    run(SEE_CMD_READ_CUR, 9'h0, 1, 1'b0, 1'b0, 1'b0, 1'b1);
    repeat (10) @(negedge clk_sys_i);
    complete_run();
  end
endmodule
